// ---- logic/cid_dispatch.sv ----
// Purpose: Interrupt gathering, gating, wake-up and vector entry
// Assumes: Sequencer supplies q_phase; peripheral enables/flags are inputs
// Notes: pc_high_latch is never driven from here
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module cid_dispatch #(
    parameter int PERIPH_N = 8,
    parameter logic [7:0] PERIPH_WAKE_MASK = 8'hff
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] q_phase,
    input wire logic [12:0] cpu_pc,
    input wire logic sleep_mode,
    input wire logic return_from_isr,
    input wire logic ext_pin,
    input wire logic timer0_wrap,
    input wire logic [cid_pkg::CID_PC_PINS-1:0] port_pins,
    input wire logic [PERIPH_N-1:0] periph_flags,
    input wire logic [PERIPH_N-1:0] periph_enables,
    output logic flush_prefetch,
    output logic stack_push,
    output logic [12:0] stack_push_data,
    output logic pc_load,
    output logic [12:0] pc_load_value,
    output logic wake,
    output logic irq_request
);
    import cid_pkg::*;

    initial
    begin
        if (PERIPH_N < 1 || PERIPH_N > 8)
        begin
            $error("PERIPH_N must be 1 to 8");
        end
    end

    // ==========================================================
    // State
    logic [7:0] control_reg;
    logic [8:0] option_reg;
    cid_state_t state_reg;
    logic pin_prev_reg;
    logic [CID_PC_PINS-1:0] port_prev_reg;
    logic [1:0] hold_reg;
    logic [12:0] ret_addr_reg;
    logic push_reg;
    logic wake_reg;
    logic wake_cond_reg;
    logic [31:0] rdata_reg;

    logic wr_ctl;
    logic wr_opt;
    logic pin_edge;
    logic port_change;
    logic core_hits;
    logic periph_hits;
    logic accept;
    logic wake_cond;
    logic [PERIPH_N-1:0] wake_mask;

    function automatic logic addr_mapped(input logic [7:0] a);
        if (a == CID_OFS_CONTROL)
            return 1'b1;
        else if (a == CID_OFS_OPTION)
            return 1'b1;
        else if (a == CID_OFS_STATUS)
            return 1'b1;
        else
            return 1'b0;
    endfunction : addr_mapped

    // ==========================================================
    // APB slave, zero wait states
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign wr_ctl = psel && penable && pwrite && paddr == CID_OFS_CONTROL;
    assign wr_opt = psel && penable && pwrite && paddr == CID_OFS_OPTION;
    assign prdata = rdata_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata_reg <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == CID_OFS_CONTROL)
                rdata_reg <= {24'h000000, control_reg};
            else if (paddr == CID_OFS_OPTION)
                rdata_reg <= {23'h000000, option_reg};
            else if (paddr == CID_OFS_STATUS)
                rdata_reg <= {26'h0000000, hold_reg, state_reg, sleep_mode,
                    irq_request};
            else
                rdata_reg <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            option_reg <= CID_OPTION_RST;
        else if (wr_opt)
            option_reg <= pwdata[8:0];
    end

    // ==========================================================
    // Source edge detection
    // Pin flag may set in any phase, including Q4 to Q1
    assign pin_edge = option_reg[CID_BIT_EDGE] ? (ext_pin && !pin_prev_reg)
        : (!ext_pin && pin_prev_reg);
    assign port_change = |((port_pins ^ port_prev_reg)
        & option_reg[CID_PC_PINS-1:0]);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_prev_reg <= 1'b0;
            port_prev_reg <= '0;
        end
        else
        begin
            pin_prev_reg <= ext_pin;
            port_prev_reg <= port_pins;
        end
    end

    // ==========================================================
    // Control register: set wins over software clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            control_reg <= CID_CONTROL_RST;
        else
        begin
            if (wr_ctl)
                control_reg <= pwdata[7:0];
            if (accept)
                control_reg[CID_BIT_GIE] <= 1'b0;
            else if (return_from_isr)
                control_reg[CID_BIT_GIE] <= 1'b1;
            if (timer0_wrap)
                control_reg[CID_BIT_T0IF] <= 1'b1;
            if (pin_edge)
                control_reg[CID_BIT_PINIF] <= 1'b1;
            if (port_change)
                control_reg[CID_BIT_PCIF] <= 1'b1;
        end
    end

    // ==========================================================
    // Request combination
    assign core_hits = (control_reg[CID_BIT_T0IE] && control_reg[CID_BIT_T0IF])
        || (control_reg[CID_BIT_PINIE] && control_reg[CID_BIT_PINIF])
        || (control_reg[CID_BIT_PCIE] && control_reg[CID_BIT_PCIF]);
    assign periph_hits = control_reg[CID_BIT_PERIPHERAL_IRQ_GATE]
        && |(periph_flags & periph_enables);
    assign irq_request = control_reg[CID_BIT_GIE]
        && (core_hits || periph_hits);

    // Acceptance only in Q1, never during post-wake hold
    assign accept = irq_request && q_phase == CID_Q1
        && state_reg == CID_ST_IDLE && hold_reg == 2'h0 && !sleep_mode;

    // ==========================================================
    // Entry sequencer: finish, flush, call; counted in cycles only
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_reg <= CID_ST_IDLE;
        else
        begin
            case (state_reg)
                CID_ST_IDLE:
                    if (accept)
                        state_reg <= CID_ST_FINISH;
                CID_ST_FINISH:
                    if (q_phase == CID_Q4)
                        state_reg <= CID_ST_FLUSH;
                CID_ST_FLUSH:
                    if (q_phase == CID_Q4)
                        state_reg <= CID_ST_CALL;
                CID_ST_CALL:
                    if (q_phase == CID_Q4)
                        state_reg <= CID_ST_IDLE;
                default:
                    state_reg <= CID_ST_IDLE;
            endcase
        end
    end

    assign flush_prefetch = state_reg == CID_ST_FLUSH;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ret_addr_reg <= 13'h0000;
        else if (state_reg == CID_ST_FINISH && q_phase == CID_Q4)
            ret_addr_reg <= cpu_pc;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            push_reg <= 1'b0;
        else
            push_reg <= state_reg == CID_ST_CALL && q_phase == CID_Q4;
    end

    // Vector entry: only return PC pushed, high latch left alone
    assign stack_push = push_reg;
    assign stack_push_data = ret_addr_reg;
    assign pc_load = push_reg;
    assign pc_load_value = CID_VECTOR;

    // ==========================================================
    // Sleep wake-up
    // Timer0 stops with the clock, so it cannot wake
    assign wake_mask = PERIPH_WAKE_MASK[PERIPH_N-1:0];
    assign wake_cond = (control_reg[CID_BIT_PINIE] && control_reg[CID_BIT_PINIF])
        || (control_reg[CID_BIT_PCIE] && control_reg[CID_BIT_PCIF])
        || (control_reg[CID_BIT_PERIPHERAL_IRQ_GATE]
        && |(periph_flags & periph_enables & wake_mask));

    // Single wake pulse per rise of the wake condition in sleep, even while the source stays pending
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            wake_cond_reg <= 1'b0;
        else
            wake_cond_reg <= sleep_mode && wake_cond;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            wake_reg <= 1'b0;
        else
            wake_reg <= sleep_mode && wake_cond && !wake_cond_reg;
    end

    assign wake = wake_reg;

    // Hold off entry until the instruction after sleep completes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hold_reg <= 2'h0;
        else if (wake_reg)
            hold_reg <= CID_WAKE_HOLD_TCY;
        else if (hold_reg != 2'h0 && q_phase == CID_Q4)
            hold_reg <= hold_reg - 2'h1;
    end

    // ==========================================================
    // Checks
    sequence s_accept;
        accept;
    endsequence

    sequence s_entry;
        state_reg == CID_ST_FINISH ##1 !stack_push [*8] ##1 !stack_push [*2]
        ##1 stack_push;
    endsequence

    property p_latency;
        @(posedge clk) disable iff (!rstn)
        s_accept |=> s_entry;
    endproperty

    a_entry_latency_cycles: assert property (p_latency)
        else $error("vector entry not three instruction cycles after Q1");

    a_sample_in_q1: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == CID_ST_IDLE ##1 state_reg == CID_ST_FINISH
        |-> $past(q_phase) == CID_Q1)
        else $error("interrupt accepted outside Q1");

    a_gie_cleared_entry: assert property (@(posedge clk) disable iff (!rstn)
        accept |=> !control_reg[CID_BIT_GIE])
        else $error("global enable not cleared on entry");

    a_return_sets_gie: assert property (@(posedge clk) disable iff (!rstn)
        return_from_isr && !accept && !wr_ctl |=> control_reg[CID_BIT_GIE])
        else $error("return from ISR did not set global enable");

    a_pin_flag_sets: assert property (@(posedge clk) disable iff (!rstn)
        pin_edge |=> control_reg[CID_BIT_PINIF])
        else $error("selected pin edge lost");

    a_accept_needs_enable: assert property (@(posedge clk) disable iff (!rstn)
        accept |-> control_reg[CID_BIT_GIE] && (core_hits || periph_hits))
        else $error("entry without enabled source");

    a_vector_on_push: assert property (@(posedge clk) disable iff (!rstn)
        stack_push |-> pc_load && pc_load_value == 13'h0004
        && stack_push_data == $past(ret_addr_reg))
        else $error("push without vector load");

    a_flush_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
        $rose(flush_prefetch) |-> flush_prefetch [*4] ##1 !flush_prefetch)
        else $error("flush does not last one instruction cycle");

    a_wake_hold_off: assert property (@(posedge clk) disable iff (!rstn)
        wake |=> !accept [*4])
        else $error("entry taken before post-sleep instruction");

endmodule : cid_dispatch

`default_nettype wire

// ---- pkg/cid_pkg.sv ----
// Purpose: Constants for the core interrupt dispatch block
// Assumes: One clk edge per Q phase, four phases per instruction cycle
// Notes: Byte offsets on a 32-bit APB register bus
package cid_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] CID_OFS_CONTROL = 8'h00;
    localparam logic [7:0] CID_OFS_OPTION = 8'h04;
    localparam logic [7:0] CID_OFS_STATUS = 8'h08;

    // ==========================================================
    // Control register fields
    localparam int CID_BIT_GIE = 7;
    localparam int CID_BIT_PERIPHERAL_IRQ_GATE = 6;
    localparam int CID_BIT_T0IE = 5;
    localparam int CID_BIT_PINIE = 4;
    localparam int CID_BIT_PCIE = 3;
    localparam int CID_BIT_T0IF = 2;
    localparam int CID_BIT_PINIF = 1;
    localparam int CID_BIT_PCIF = 0;
    localparam logic [7:0] CID_CONTROL_RST = 8'h00;

    // Option register fields: edge select, per-pin change enables
    localparam int CID_BIT_EDGE = 8;
    localparam int CID_PC_PINS = 4;
    localparam logic [8:0] CID_OPTION_RST = 9'h100;

    // ==========================================================
    // Sequencer phases and timing
    localparam logic [1:0] CID_Q1 = 2'h0;
    localparam logic [1:0] CID_Q4 = 2'h3;
    localparam int CID_ENTRY_TCY = 3;
    localparam logic [1:0] CID_WAKE_HOLD_TCY = 2'h2;
    localparam logic [12:0] CID_VECTOR = 13'h0004;

    typedef enum logic [1:0] {
        CID_ST_IDLE,
        CID_ST_FINISH,
        CID_ST_FLUSH,
        CID_ST_CALL
    } cid_state_t;

endpackage : cid_pkg

// ---- verification/cid_cpu_model.sv ----
// Purpose: CPU sequencer stand-in facing the dispatch block
// Assumes: One clk edge per Q phase, four phases per cycle
// Notes: PC advances once per instruction cycle, vector load wins
`timescale 1ns/100ps
`default_nettype none
module cid_cpu_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pc_load,
    input wire logic [12:0] pc_load_value,
    output logic [1:0] q_phase,
    output logic [12:0] cpu_pc
);
    import cid_pkg::*;
    // ==========================================================
    // Phase counter and program counter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q_phase <= CID_Q1;
            cpu_pc <= 13'h0010;
        end
        else
        begin
            q_phase <= q_phase + 2'h1;
            if (pc_load)
                cpu_pc <= pc_load_value;
            else if (q_phase == CID_Q4)
                cpu_pc <= cpu_pc + 13'h0001;
        end
    end
endmodule : cid_cpu_model
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the interrupt dispatch block
// Assumes: APB slave answers with pready, sequencer model beside it
// Notes: Expected values come from the control register layout
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
    begin \
        total_checks++; \
        if ((a) !== (b)) \
        begin \
            num_errors++; \
            $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); \
        end \
    end
module testbench;
    import cid_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e;
    logic [1:0] q_phase;
    logic [12:0] cpu_pc, pc, stack_push_data, pc_load_value;
    logic sleep_mode = 1'b0, return_from_isr = 1'b0, ext_pin = 1'b0;
    logic timer0_wrap = 1'b0;
    logic [3:0] port_pins = 4'h0;
    logic [7:0] periph_flags = 8'h00, periph_enables = 8'h00;
    logic flush_prefetch, stack_push, pc_load, wake, irq_request;
    int num_errors = 0, total_checks = 0, cycles = 0, n, fl, w;
    always #5 clk = ~clk;
    cid_dispatch uut (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .q_phase(q_phase), .cpu_pc(cpu_pc),
        .sleep_mode(sleep_mode), .return_from_isr(return_from_isr),
        .ext_pin(ext_pin), .timer0_wrap(timer0_wrap),
        .port_pins(port_pins), .periph_flags(periph_flags),
        .periph_enables(periph_enables),
        .flush_prefetch(flush_prefetch), .stack_push(stack_push),
        .stack_push_data(stack_push_data), .pc_load(pc_load),
        .pc_load_value(pc_load_value), .wake(wake),
        .irq_request(irq_request));
    cid_cpu_model cpu (.clk(clk), .rstn(rstn), .pc_load(pc_load),
        .pc_load_value(pc_load_value), .q_phase(q_phase),
        .cpu_pc(cpu_pc));
    // ==========================================================
    // Bus access and closing
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
    endtask : settle
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    // ==========================================================
    // Scenarios
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, CID_OFS_CONTROL, 32'h0);
        `CHK(r[7:0], 8'h00)
        apb(1'b0, CID_OFS_OPTION, 32'h0);
        `CHK(r[8:0], 9'h100)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(e, 1'b1)
        apb(1'b1, CID_OFS_CONTROL, 32'h78);
        apb(1'b0, CID_OFS_CONTROL, 32'h0);
        `CHK(r[7:0], 8'h78)
        apb(1'b1, CID_OFS_CONTROL, 32'h80);
        ext_pin <= 1'b1;
        settle(8);
        apb(1'b0, CID_OFS_CONTROL, 32'h0);
        `CHK(r[7:0], 8'h82)
        `CHK(irq_request, 1'b0)
        apb(1'b1, CID_OFS_CONTROL, 32'h00);
        ext_pin <= 1'b0;
        settle(8);
        apb(1'b0, CID_OFS_CONTROL, 32'h0);
        `CHK(r[7:0], 8'h00)
        apb(1'b1, CID_OFS_OPTION, 32'h0);
        ext_pin <= 1'b1;
        settle(8);
        ext_pin <= 1'b0;
        settle(8);
        timer0_wrap <= 1'b1;
        settle(1);
        timer0_wrap <= 1'b0;
        apb(1'b0, CID_OFS_CONTROL, 32'h0);
        `CHK(r[7:0], 8'h06)
        apb(1'b1, CID_OFS_CONTROL, 32'h00);
        apb(1'b1, CID_OFS_OPTION, 32'h101);
        port_pins <= 4'h1;
        settle(8);
        apb(1'b0, CID_OFS_CONTROL, 32'h0);
        `CHK(r[0], 1'b1)
        // Peripheral source held back until the gate opens
        apb(1'b1, CID_OFS_CONTROL, 32'h80);
        periph_flags <= 8'h01;
        periph_enables <= 8'h01;
        settle(2);
        `CHK(irq_request, 1'b0)
        apb(1'b1, CID_OFS_CONTROL, 32'hc0);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (!(q_phase === CID_Q1 && irq_request === 1'b1) && n < 20);
        `CHK(irq_request, 1'b1)
        pc = cpu_pc;
        n = 0;
        fl = 0;
        do
        begin
            @(negedge clk);
            n++;
            fl += int'(flush_prefetch === 1'b1);
        end
        while (stack_push !== 1'b1 && n < 40);
        `CHK(n, 12)
        `CHK(stack_push_data, pc)
        `CHK(pc_load, 1'b1)
        `CHK(pc_load_value, CID_VECTOR)
        `CHK(fl, 4)
        @(posedge clk);
        periph_flags <= 8'h00;
        apb(1'b0, CID_OFS_CONTROL, 32'h0);
        `CHK(r[7], 1'b0)
        return_from_isr <= 1'b1;
        settle(1);
        return_from_isr <= 1'b0;
        apb(1'b0, CID_OFS_CONTROL, 32'h0);
        `CHK(r[7], 1'b1)
        // Sleep: timer cannot wake, pin edge can
        apb(1'b1, CID_OFS_CONTROL, 32'h30);
        sleep_mode <= 1'b1;
        timer0_wrap <= 1'b1;
        settle(1);
        timer0_wrap <= 1'b0;
        w = 0;
        repeat (10) @(negedge clk) w += int'(wake === 1'b1);
        `CHK(w, 0)
        @(posedge clk);
        ext_pin <= 1'b1;
        repeat (10) @(negedge clk) w += int'(wake === 1'b1);
        `CHK(w, 1)
        @(posedge clk);
        sleep_mode <= 1'b0;
        w = 0;
        repeat (40) @(negedge clk) w += int'(stack_push === 1'b1);
        `CHK(w, 0)
        // Wake with global enable set branches to the vector
        @(posedge clk);
        sleep_mode <= 1'b1;
        apb(1'b1, CID_OFS_CONTROL, 32'h92);
        sleep_mode <= 1'b0;
        w = 0;
        repeat (60) @(negedge clk) w += int'(stack_push === 1'b1);
        `CHK(w, 1)
        `CHK(pc_load_value, CID_VECTOR)
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
